/* File: rtl/half_bridge_gate_sequencer.sv */
// Gate drive sequencer, drive strength decode and amplifier output control
module half_bridge_gate_sequencer (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic serial_variant,
    input wire logic bridge_pwm_input,
    input wire logic bridge_float_n,
    input wire logic high_gate_monitor,
    input wire logic low_gate_monitor,
    input wire logic [3:0] source_strength_code,
    input wire logic [3:0] sink_strength_code,
    input wire logic [3:0] slew_strength_control,
    input wire gate_seq_pkg::seq_config_type seq_config,
    input wire gate_seq_pkg::amp_config_type amp_config,
    input wire logic [1:0] amp_gain_pin,
    input wire logic brake_high_side,
    input wire logic brake_low_side,
    input wire logic other_bridge_edge,
    input wire logic fault_clear,
    output logic high_gate_output,
    output logic low_gate_output,
    output logic high_strong_pulldown,
    output logic low_strong_pulldown,
    output logic peak_drive_active,
    output logic pullup_hold,
    output logic monitor_blank,
    output logic [6:0] source_drive_level,
    output logic [6:0] sink_drive_level,
    output logic high_gate_fault,
    output logic low_gate_fault,
    output logic [6:0] amp_stage2_gain,
    output logic [6:0] amp_total_gain,
    output logic [1:0] amp_ref_divider_sel,
    output logic amp_output_connect
);

    // ==================================================
    // Reset release
    logic rst_meta_reg;
    logic rst_n_sync;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // ==================================================
    // Pin synchronisers
    logic [gate_seq_pkg::SYNC_COUNT-1:0] pin_raw;
    logic [gate_seq_pkg::SYNC_COUNT-1:0] pin_v;

    assign pin_raw = {low_gate_monitor, high_gate_monitor, bridge_float_n, bridge_pwm_input};

    // Change accepted only when stages two and three agree
    for (genvar i = 0; i < gate_seq_pkg::SYNC_COUNT; i++) begin : sync_g
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        logic val_reg;
        always_ff @(posedge clk_sys or negedge rst_n_sync) begin
            if (!rst_n_sync) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                s3_reg <= 1'b0;
                val_reg <= 1'b0;
            end else begin
                s1_reg <= pin_raw[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                if (s2_reg == s3_reg) begin
                    val_reg <= s3_reg;
                end
            end
        end
        assign pin_v[i] = val_reg;
    end

    logic pwm_v;
    logic float_n_v;
    logic mon_high_v;
    logic mon_low_v;

    assign pwm_v = pin_v[gate_seq_pkg::SYNC_PWM];
    assign float_n_v = pin_v[gate_seq_pkg::SYNC_FLOAT];
    assign mon_high_v = pin_v[gate_seq_pkg::SYNC_MON_HIGH];
    assign mon_low_v = pin_v[gate_seq_pkg::SYNC_MON_LOW];

    // ==================================================
    // Break-before-make sequencer
    gate_seq_pkg::seq_state_type state_reg;
    gate_seq_pkg::seq_state_type state_next;
    logic target_reg;
    logic target_next;
    logic [7:0] dead_cnt_reg;
    logic [7:0] dead_cnt_next;
    logic [7:0] dead_len;
    logic [7:0] win_len;
    logic off_gate_clear;
    gate_seq_pkg::seq_state_type on_state;

    assign dead_len = seq_config.digital_dead_time_setting;
    assign win_len = seq_config.drive_window_length;
    // Off-going gate is the one opposite the requested side
    assign off_gate_clear = pwm_v ? !mon_low_v : !mon_high_v;
    assign on_state = pwm_v ? gate_seq_pkg::ST_HIGH : gate_seq_pkg::ST_LOW;

    always_comb begin
        state_next = state_reg;
        target_next = target_reg;
        dead_cnt_next = dead_cnt_reg;
        if (!float_n_v) begin
            state_next = gate_seq_pkg::ST_OFF;
        end else begin
            unique case (state_reg)
                gate_seq_pkg::ST_OFF: begin
                    target_next = pwm_v;
                    state_next = gate_seq_pkg::ST_BREAK;
                end
                gate_seq_pkg::ST_HIGH: begin
                    if (!pwm_v) begin
                        target_next = 1'b0;
                        state_next = gate_seq_pkg::ST_BREAK;
                    end
                end
                gate_seq_pkg::ST_LOW: begin
                    if (pwm_v) begin
                        target_next = 1'b1;
                        state_next = gate_seq_pkg::ST_BREAK;
                    end
                end
                gate_seq_pkg::ST_BREAK: begin
                    target_next = pwm_v;
                    if (off_gate_clear) begin
                        dead_cnt_next = dead_len;
                        // Zero setting skips the digital dead time
                        state_next = (dead_len == 8'h00) ? on_state : gate_seq_pkg::ST_DEAD;
                    end
                end
                gate_seq_pkg::ST_DEAD: begin
                    if (pwm_v != target_reg) begin
                        state_next = gate_seq_pkg::ST_BREAK;
                    end else if (dead_cnt_reg <= 8'h01) begin
                        state_next = on_state;
                    end else begin
                        dead_cnt_next = dead_cnt_reg - 8'h01;
                    end
                end
                default: begin
                    state_next = gate_seq_pkg::ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_reg <= gate_seq_pkg::ST_OFF;
            target_reg <= 1'b0;
            dead_cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            target_reg <= target_next;
            dead_cnt_reg <= dead_cnt_next;
        end
    end

    assign high_gate_output = (state_reg == gate_seq_pkg::ST_HIGH);
    assign low_gate_output = (state_reg == gate_seq_pkg::ST_LOW);

    // ==================================================
    // Drive window, strong pulldown and gate fault check
    logic high_next;
    logic low_next;
    logic edge_high;
    logic edge_low;
    logic win_load;
    logic [7:0] win_cnt_reg;
    logic [7:0] win_cnt_next;
    logic win_high_reg;
    logic win_level_reg;
    logic win_expire;
    logic win_mismatch;
    logic high_fault_reg;
    logic low_fault_reg;

    assign high_next = (state_next == gate_seq_pkg::ST_HIGH);
    assign low_next = (state_next == gate_seq_pkg::ST_LOW);
    assign edge_high = high_next != high_gate_output;
    assign edge_low = low_next != low_gate_output;
    assign win_load = edge_high || edge_low;
    // A fresh edge restarts the window; the old one is dropped unchecked
    assign win_cnt_next = win_load ? win_len : (win_cnt_reg != 8'h00) ? win_cnt_reg - 8'h01 : 8'h00;
    assign win_expire = (win_cnt_reg == 8'h01) && !win_load;
    assign win_mismatch = (win_high_reg ? mon_high_v : mon_low_v) != win_level_reg;

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            win_cnt_reg <= 8'h00;
            win_high_reg <= 1'b0;
            win_level_reg <= 1'b0;
            high_fault_reg <= 1'b0;
            low_fault_reg <= 1'b0;
        end else begin
            win_cnt_reg <= win_cnt_next;
            if (win_load) begin
                win_high_reg <= edge_high;
                win_level_reg <= edge_high ? high_next : low_next;
            end
            // Set beats clear in the same cycle
            high_fault_reg <= (win_expire && win_mismatch && win_high_reg) || (high_fault_reg && !fault_clear);
            low_fault_reg <= (win_expire && win_mismatch && !win_high_reg) || (low_fault_reg && !fault_clear);
        end
    end

    assign peak_drive_active = (win_cnt_reg != 8'h00);
    assign pullup_hold = !peak_drive_active;
    assign monitor_blank = peak_drive_active;
    assign high_strong_pulldown = peak_drive_active && !win_high_reg;
    assign low_strong_pulldown = peak_drive_active && win_high_reg;
    assign high_gate_fault = high_fault_reg;
    assign low_gate_fault = low_fault_reg;

    // ==================================================
    // Drive strength and amplifier gain
    logic [3:0] src_code;
    logic [3:0] snk_code;
    logic [1:0] gain_code;

    assign src_code = serial_variant ? source_strength_code : slew_strength_control;
    assign snk_code = serial_variant ? sink_strength_code : slew_strength_control;
    assign gain_code = serial_variant ? amp_config.amp_gain_select : amp_gain_pin;

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            source_drive_level <= gate_seq_pkg::DRIVE_LEVEL_RESET;
            sink_drive_level <= gate_seq_pkg::DRIVE_LEVEL_RESET;
            amp_stage2_gain <= gate_seq_pkg::STAGE2_GAIN_RESET;
            amp_total_gain <= gate_seq_pkg::TOTAL_GAIN_RESET;
            amp_ref_divider_sel <= gate_seq_pkg::REF_DIV_HALF;
        end else begin
            source_drive_level <= gate_seq_pkg::DRIVE_LEVEL_TABLE[src_code];
            sink_drive_level <= gate_seq_pkg::DRIVE_LEVEL_TABLE[snk_code];
            amp_stage2_gain <= gate_seq_pkg::STAGE2_GAIN_TABLE[gain_code];
            amp_total_gain <= 7'(gate_seq_pkg::FIRST_STAGE_GAIN * gate_seq_pkg::STAGE2_GAIN_TABLE[gain_code]);
            amp_ref_divider_sel <= serial_variant ? amp_config.amp_reference_divider : gate_seq_pkg::REF_DIV_HALF;
        end
    end

    // ==================================================
    // Amplifier output blanking and hold
    gate_seq_pkg::amp_config_type amp_cfg_reg;
    logic [7:0] blank_cnt_reg;
    logic [7:0] blank_cnt_next;
    logic blank_trigger;
    logic hold_now;
    logic connect_reg;

    assign blank_trigger = amp_cfg_reg.blank_source_select ? other_bridge_edge : win_load;
    // Counter starts on the edge that moves the gate, or on other_bridge_edge when blank_source_select is set
    assign blank_cnt_next = (serial_variant && amp_cfg_reg.blank_enable && blank_trigger)
        ? amp_cfg_reg.blank_period_select
        : (blank_cnt_reg != 8'h00) ? blank_cnt_reg - 8'h01 : 8'h00;
    assign hold_now = serial_variant && amp_cfg_reg.hold_on_brake_enable && (brake_high_side || brake_low_side);

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            amp_cfg_reg <= gate_seq_pkg::AMP_CONFIG_RESET;
            blank_cnt_reg <= 8'h00;
            connect_reg <= 1'b1;
        end else begin
            amp_cfg_reg <= amp_config;
            blank_cnt_reg <= blank_cnt_next;
            // Hardware variant never opens the switch
            connect_reg <= !serial_variant || ((blank_cnt_next == 8'h00) && !hold_now);
        end
    end

    assign amp_output_connect = connect_reg;

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n_sync);

    gates_exclusive_a: assert property (!(high_gate_output && low_gate_output))
        else $error("both gates on");
    break_first_a: assert property ($rose(high_gate_output) |-> !$past(mon_low_v) && !$past(low_gate_output))
        else $error("high gate on before low gate discharged");
    dead_inserted_a: assert property ($rose(low_gate_output) && $past(dead_len) != 8'h00
        |-> $past(state_reg) == gate_seq_pkg::ST_DEAD)
        else $error("digital dead time skipped");
    float_off_a: assert property (!float_n_v |=> !high_gate_output && !low_gate_output)
        else $error("gate on while floating");
    window_reload_a: assert property (win_load |=> win_cnt_reg == $past(win_len))
        else $error("window not restarted on edge");
    opposite_pulldown_a: assert property (win_load && edge_high && win_len != 8'h00
        |=> low_strong_pulldown && !high_strong_pulldown)
        else $error("strong pulldown missing on opposite gate");
    gate_fault_a: assert property (win_expire && win_mismatch && win_high_reg && !fault_clear
        |=> high_gate_fault ##1 (high_gate_fault || $past(fault_clear)))
        else $error("high gate fault not flagged");
    gain_total_a: assert property (##1 amp_total_gain == 7'(amp_stage2_gain << 1))
        else $error("total gain not twice second stage");
    hw_connected_a: assert property (!serial_variant |=> amp_output_connect)
        else $error("output switched on hardware variant");
    hold_brake_a: assert property (serial_variant && amp_cfg_reg.hold_on_brake_enable && brake_low_side
        |=> !amp_output_connect)
        else $error("output not held while braking");

endmodule : half_bridge_gate_sequencer

/* File: common/gate_seq_pkg.sv */
// Shared constants and types of the half-bridge gate sequencer
package gate_seq_pkg;

    // ==================================================
    // Field widths
    localparam int STRENGTH_W = 4;
    localparam int LEVEL_W = 7;
    localparam int WINDOW_W = 8;
    localparam int DEAD_W = 8;
    localparam int BLANK_W = 8;
    localparam int GAIN_W = 2;
    localparam int REF_DIV_W = 2;

    // ==================================================
    // Synchronised pin indices
    localparam int SYNC_PWM = 0;
    localparam int SYNC_FLOAT = 1;
    localparam int SYNC_MON_HIGH = 2;
    localparam int SYNC_MON_LOW = 3;
    localparam int SYNC_COUNT = 4;

    // ==================================================
    // Drive strength in half-milliamp steps, indexed by 4-bit code
    localparam logic [6:0] DRIVE_LEVEL_TABLE [16] = '{
        7'h01, 7'h02, 7'h04, 7'h06, 7'h08, 7'h0C, 7'h10, 7'h18,
        7'h20, 7'h28, 7'h30, 7'h38, 7'h3E, 7'h50, 7'h60, 7'h7C
    };
    localparam logic [6:0] DRIVE_LEVEL_RESET = 7'h01;

    // ==================================================
    // Amplifier gain and reference divider
    localparam logic [6:0] FIRST_STAGE_GAIN = 7'h02;
    localparam logic [6:0] STAGE2_GAIN_TABLE [4] = '{7'h05, 7'h0A, 7'h14, 7'h28};
    localparam logic [6:0] STAGE2_GAIN_RESET = 7'h05;
    localparam logic [6:0] TOTAL_GAIN_RESET = 7'h0A;
    // Divider code meaning one half; value is arbitrary
    localparam logic [1:0] REF_DIV_HALF = 2'h0;

    // ==================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_BREAK = 3'b001,
        ST_DEAD = 3'b010,
        ST_HIGH = 3'b011,
        ST_LOW = 3'b100
    } seq_state_type;

    typedef struct packed {
        logic [7:0] drive_window_length;
        logic [7:0] digital_dead_time_setting;
    } seq_config_type;

    typedef struct packed {
        logic blank_enable;
        logic blank_source_select;
        logic [7:0] blank_period_select;
        logic hold_on_brake_enable;
        logic [1:0] amp_gain_select;
        logic [1:0] amp_reference_divider;
    } amp_config_type;

    localparam amp_config_type AMP_CONFIG_RESET = '0;

endpackage : gate_seq_pkg

/* File: tb/gate_model.sv */
// Behavioural external MOSFET pair whose gate monitors follow the gate drives
module gate_model (
    input wire logic clk_sys,
    input wire logic high_gate_output,
    input wire logic low_gate_output,
    input wire logic [3:0] slew_cycles,
    input wire logic high_stuck_low,
    output logic high_gate_monitor,
    output logic low_gate_monitor
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] high_cnt_reg = 4'h0;
    logic [3:0] low_cnt_reg = 4'h0;
    initial begin
        high_gate_monitor = 1'b0;
        low_gate_monitor = 1'b0;
    end
    // ==================================================
    // Gate charge
    // Slow gates: monitor lags the drive by slew_cycles plus one edges; a stuck gate never rises
    always @(posedge clk_sys) begin
        if (high_gate_output == high_gate_monitor) begin
            high_cnt_reg <= 4'h0;
        end else if (high_cnt_reg < slew_cycles) begin
            high_cnt_reg <= high_cnt_reg + 4'h1;
        end else begin
            high_gate_monitor <= high_gate_output & ~high_stuck_low;
        end
        if (low_gate_output == low_gate_monitor) begin
            low_cnt_reg <= 4'h0;
        end else if (low_cnt_reg < slew_cycles) begin
            low_cnt_reg <= low_cnt_reg + 4'h1;
        end else begin
            low_gate_monitor <= low_gate_output;
        end
    end
endmodule : gate_model

/* File: tb/tb_top.sv */
// Self-checking testbench of the half-bridge gate sequencer
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic serial_variant = 1'b1;
    logic bridge_pwm_input = 1'b0;
    logic bridge_float_n = 1'b1;
    logic high_gate_monitor, low_gate_monitor, high_stuck_low = 1'b0;
    logic [3:0] source_strength_code = 4'h0;
    logic [3:0] sink_strength_code = 4'h0;
    logic [3:0] slew_strength_control = 4'h0;
    logic [3:0] slew_cycles = 4'h3;
    gate_seq_pkg::seq_config_type seq_config = 16'h1400;
    gate_seq_pkg::amp_config_type amp_config = gate_seq_pkg::AMP_CONFIG_RESET;
    logic [1:0] amp_gain_pin = 2'h0;
    logic brake_high_side = 1'b0;
    logic brake_low_side = 1'b0;
    logic other_bridge_edge = 1'b0;
    logic fault_clear = 1'b0;
    logic high_gate_output, low_gate_output, high_strong_pulldown, low_strong_pulldown;
    logic peak_drive_active, pullup_hold, monitor_blank, high_gate_fault, low_gate_fault, amp_output_connect;
    logic [6:0] source_drive_level, sink_drive_level, amp_stage2_gain, amp_total_gain;
    logic [1:0] amp_ref_divider_sel;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    int g0;
    int g1;
    // Strength in half-milliamp steps
    logic [6:0] level_t [16] = '{7'h01, 7'h02, 7'h04, 7'h06, 7'h08, 7'h0C, 7'h10, 7'h18,
        7'h20, 7'h28, 7'h30, 7'h38, 7'h3E, 7'h50, 7'h60, 7'h7C};
    logic [6:0] stage2_t [4] = '{7'h05, 7'h0A, 7'h14, 7'h28};

    half_bridge_gate_sequencer half_bridge_gate_sequencer_i (.clk_sys, .rstn, .serial_variant,
        .bridge_pwm_input, .bridge_float_n, .high_gate_monitor, .low_gate_monitor, .source_strength_code,
        .sink_strength_code, .slew_strength_control, .seq_config, .amp_config, .amp_gain_pin,
        .brake_high_side, .brake_low_side, .other_bridge_edge, .fault_clear, .high_gate_output,
        .low_gate_output, .high_strong_pulldown, .low_strong_pulldown, .peak_drive_active, .pullup_hold,
        .monitor_blank, .source_drive_level, .sink_drive_level, .high_gate_fault, .low_gate_fault,
        .amp_stage2_gain, .amp_total_gain, .amp_ref_divider_sel, .amp_output_connect);
    gate_model gate_model_i (.clk_sys, .high_gate_output, .low_gate_output, .slew_cycles,
        .high_stuck_low, .high_gate_monitor, .low_gate_monitor);

    // ==================================================
    // Clock, timeout and helpers
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            $display("CHECK FAILED run time limit expected %0d seen %0d", 5999, cycles);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask : step
    function automatic logic pick(input int w);
        case (w)
            0: return high_gate_output;
            1: return low_gate_output;
            2: return amp_output_connect;
            default: return peak_drive_active;
        endcase
    endfunction : pick
    // Edges until the watched output reaches v; bounded so a hang shows up as a mismatch
    task automatic wait_for(input int w, input logic v, output int k);
        k = 1;
        step();
        while (pick(w) !== v && k < 300) begin
            step();
            k++;
        end
    endtask : wait_for
    task automatic run_len(input int w, input logic v, output int k);
        k = 0;
        while (pick(w) === v && k < 300) begin
            step();
            k++;
        end
    endtask : run_len
    task automatic set_pwm(input logic v);
        @(posedge clk_sys);
        bridge_pwm_input <= v;
    endtask : set_pwm
    // High to low transfer; gap is the break-to-make time
    task automatic measure(output int gap);
        set_pwm(1'b0);
        wait_for(0, 1'b0, n);
        `CHK("low pulldown at high edge", 1'b1, low_strong_pulldown)
        wait_for(1, 1'b1, gap);
        `CHK("high monitor at make", 1'b0, high_gate_monitor)
        `CHK("no pulldown on moving gate", 1'b0, low_strong_pulldown)
        `CHK("opposite pulldown", 1'b1, high_strong_pulldown)
        `CHK("monitor blank", 1'b1, monitor_blank)
        `CHK("hold current in window", 1'b0, pullup_hold)
        run_len(3, 1'b1, n);
        `CHK("window length", seq_config.drive_window_length, 8'(n))
        `CHK("hold current after", 1'b1, pullup_hold)
        set_pwm(1'b1);
        wait_for(0, 1'b1, n);
        repeat (40) step();
    endtask : measure

    // ==================================================
    // Scenarios
    task automatic test_levels();
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            serial_variant <= 1'b1;
            source_strength_code <= 4'(i);
            sink_strength_code <= 4'(15 - i);
            amp_config.amp_gain_select <= 2'(i);
            amp_config.amp_reference_divider <= 2'(i >> 2);
            amp_gain_pin <= 2'(~i);
            slew_strength_control <= 4'(i);
            repeat (3) step();
            `CHK("source level", level_t[i], source_drive_level)
            `CHK("sink level", level_t[15 - i], sink_drive_level)
            `CHK("stage2 gain", stage2_t[i % 4], amp_stage2_gain)
            `CHK("total gain", stage2_t[i % 4] * 2, amp_total_gain)
            `CHK("ref divider", 2'(i >> 2), amp_ref_divider_sel)
            @(posedge clk_sys);
            serial_variant <= 1'b0;
            repeat (3) step();
            `CHK("pin sink level", level_t[i], sink_drive_level)
            `CHK("pin source level", level_t[i], source_drive_level)
            `CHK("pin gain", stage2_t[3 - i % 4], amp_stage2_gain)
            `CHK("pin ref divider", gate_seq_pkg::REF_DIV_HALF, amp_ref_divider_sel)
        end
        @(posedge clk_sys);
        serial_variant <= 1'b1;
        $display("test levels done");
    endtask : test_levels
    task automatic test_switch();
        set_pwm(1'b1);
        wait_for(0, 1'b1, n);
        `CHK("low off while high on", 1'b0, low_gate_output)
        repeat (30) step();
        measure(g0);
        @(posedge clk_sys);
        seq_config.digital_dead_time_setting <= 8'h05;
        measure(g1);
        `CHK("dead time", 5, g1 - g0)
        @(posedge clk_sys);
        seq_config <= 16'h1400; // Window well beyond the gate slew
        $display("test switch done");
    endtask : test_switch
    task automatic test_fault();
        set_pwm(1'b0);
        wait_for(1, 1'b1, n);
        repeat (30) step();
        @(posedge clk_sys);
        high_stuck_low <= 1'b1;
        bridge_pwm_input <= 1'b1;
        wait_for(0, 1'b1, n);
        run_len(3, 1'b1, n);
        repeat (2) step();
        `CHK("high gate fault", 1'b1, high_gate_fault)
        `CHK("low gate fault", 1'b0, low_gate_fault)
        @(posedge clk_sys);
        fault_clear <= 1'b1;
        @(posedge clk_sys);
        fault_clear <= 1'b0;
        repeat (2) step();
        `CHK("fault cleared", 1'b0, high_gate_fault)
        set_pwm(1'b0);
        wait_for(1, 1'b1, n);
        repeat (30) step();
        // Short pulse cuts the window before the stuck gate is judged
        set_pwm(1'b1);
        wait_for(0, 1'b1, n);
        set_pwm(1'b0);
        repeat (60) step();
        `CHK("no fault on cut window", 1'b0, high_gate_fault)
        `CHK("short pulse passed", 1'b1, low_gate_output)
        @(posedge clk_sys);
        high_stuck_low <= 1'b0;
        bridge_float_n <= 1'b0;
        repeat (12) step();
        `CHK("float low side", 1'b0, low_gate_output)
        set_pwm(1'b1);
        repeat (12) step();
        `CHK("float high side", 1'b0, high_gate_output)
        @(posedge clk_sys);
        bridge_float_n <= 1'b1;
        wait_for(0, 1'b1, n);
        `CHK("float release", 1'b1, high_gate_output)
        repeat (30) step();
        $display("test fault done");
    endtask : test_fault
    task automatic test_amp();
        @(posedge clk_sys);
        amp_config.blank_enable <= 1'b1;
        amp_config.blank_period_select <= 8'h02;
        repeat (3) step();
        set_pwm(1'b0);
        wait_for(0, 1'b0, n);
        `CHK("blank at off edge", 1'b0, amp_output_connect)
        run_len(2, 1'b0, n);
        `CHK("blank period", 2, n)
        wait_for(1, 1'b1, n);
        `CHK("blank at on edge", 1'b0, amp_output_connect)
        repeat (30) step();
        @(posedge clk_sys);
        amp_config.blank_source_select <= 1'b1;
        amp_config.blank_period_select <= 8'h07;
        repeat (3) step();
        set_pwm(1'b1);
        wait_for(0, 1'b1, n);
        `CHK("own edge ignored", 1'b1, amp_output_connect)
        repeat (30) step();
        @(posedge clk_sys);
        other_bridge_edge <= 1'b1;
        @(posedge clk_sys);
        other_bridge_edge <= 1'b0;
        #1;
        run_len(2, 1'b0, n);
        `CHK("other bridge blank", 7, n)
        @(posedge clk_sys);
        amp_config.blank_enable <= 1'b0;
        amp_config.hold_on_brake_enable <= 1'b1;
        repeat (3) step();
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys);
            brake_high_side <= (s == 0);
            brake_low_side <= (s == 1);
            wait_for(2, 1'b0, n);
            `CHK("hold opens", 1, n)
            @(posedge clk_sys);
            brake_high_side <= 1'b0;
            brake_low_side <= 1'b0;
            wait_for(2, 1'b1, n);
            `CHK("reconnect", 1, n)
        end
        @(posedge clk_sys);
        serial_variant <= 1'b0;
        brake_low_side <= 1'b1;
        repeat (5) step();
        `CHK("no hold on pin variant", 1'b1, amp_output_connect)
        $display("test amp done");
    endtask : test_amp

    initial begin
        repeat (6) step();
        `CHK("connect in reset", 1'b1, amp_output_connect)
        `CHK("gates off in reset", 1'b0, high_gate_output | low_gate_output)
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (12) step();
        test_levels();
        test_switch();
        test_fault();
        test_amp();
        end_sim();
    end
endmodule : tb_top
